// [include/fbmc_defines.svh]
// timing counts, field positions and command codes for the flash bus mode controller
`ifndef FBMC_DEFINES_SVH
`define FBMC_DEFINES_SVH
`define FBMC_CLK_NS          40
`define FBMC_ACC_NS          120
`define FBMC_ACC_CYC         ((`FBMC_ACC_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_WP_NS           50
`define FBMC_WP_CYC          ((`FBMC_WP_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_RST_LOW_NS      500
`define FBMC_RST_LOW_CYC     ((`FBMC_RST_LOW_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_RECOV_NS        50
`define FBMC_RECOV_CYC       ((`FBMC_RECOV_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_SETUP_CYC       1
`define FBMC_CNT_W           5
`define FBMC_ADDR_W          20
`define FBMC_DATA_W          16
`define FBMC_BIT_ZERO_POS    0
`define FBMC_BIT_ONE_POS     1
`define FBMC_BIT_SIX_POS     6
`define FBMC_CTL_RST         7'b1111000
`define FBMC_PROT_OFS        20'h00002
`define FBMC_SECT_LSB        12
`define FBMC_CMD_READ        3'h0
`define FBMC_CMD_WRITE       3'h1
`define FBMC_CMD_ID_READ     3'h2
`define FBMC_CMD_PROTECT     3'h3
`define FBMC_CMD_UNPROTECT   3'h4
`define FBMC_CMD_RESET       3'h5
`define FBMC_CMD_PROT_CHK    3'h6
`endif

// [include/fbmc_pkg.sv]
// types for the flash bus mode controller
`include "fbmc_defines.svh"
package fbmc_pkg;
  typedef logic [`FBMC_ADDR_W-1:0] fbmc_addr_t;
  typedef logic [`FBMC_DATA_W-1:0] fbmc_data_t;
  typedef logic [`FBMC_CNT_W-1:0]  fbmc_cnt_t;
  typedef struct packed {
    logic [2:0] cmd;
    fbmc_addr_t addr;
    fbmc_data_t data;
  } fbmc_req_s;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic bit_nine_hv;
    logic oe_hv;
    logic rst_hv;
  } fbmc_ctl_s;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_SETUP = 7'b0000010,
    ST_PULSE = 7'b0000100,
    ST_WAIT  = 7'b0001000,
    ST_HOLD  = 7'b0010000,
    ST_RST   = 7'b0100000,
    ST_RECOV = 7'b1000000
  } fbmc_state_e;
endpackage

// [hdl/fbmc_timer.sv]
// down counter that flags expiry of a loaded cycle count
`timescale 1ns/100ps
module fbmc_timer
  import fbmc_pkg::*;
(
  input  wire logic      I_CLK,
  input  wire logic      I_RST_N,
  input  wire logic      i_load,
  input  wire fbmc_cnt_t i_count,
  output logic           o_done
);
  fbmc_cnt_t cnt_q, cnt_d;
  logic      done_q, done_d;

  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (i_load) begin
      cnt_d = i_count;
    end else if (cnt_q != '0) begin
      cnt_d  = cnt_q - 1'b1;
      done_d = (cnt_q == fbmc_cnt_t'(1));
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;
endmodule

// [hdl/fbmc_host.sv]
// host-side pin sequencer that drives a parallel flash through its bus modes
`timescale 1ns/100ps
module fbmc_host
  import fbmc_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic       I_RST_N,
  input  wire fbmc_req_s  I_REQ,
  input  wire logic       I_REQ_VALID,
  input  wire logic       I_TEMP_UNPROT,
  input  wire fbmc_data_t I_DQ_IN,
  output logic            O_REQ_READY,
  output fbmc_data_t      O_RD_DATA,
  output logic            O_RD_VALID,
  output logic            O_PROTECTED,
  output fbmc_ctl_s       O_CTL,
  output fbmc_addr_t      O_ADDR,
  output fbmc_data_t      O_DQ_OUT,
  output logic            O_DQ_OE
);
  fbmc_state_e st_q, st_d;
  fbmc_req_s   req_q, req_d;
  fbmc_ctl_s   ctl_q, ctl_d;
  fbmc_addr_t  addr_q, addr_d;
  fbmc_data_t  dout_q, dout_d;
  fbmc_data_t  rdat_q, rdat_d;
  logic        oe_q, oe_d;
  logic        rvld_q, rvld_d;
  logic        prot_q, prot_d;
  logic        rdy_q, rdy_d;
  logic        tload;
  fbmc_cnt_t   tcount;
  logic        tdone;
  logic        is_read;
  logic        is_hv;

  fbmc_timer u_timer (
    .I_CLK   (I_CLK),
    .I_RST_N (I_RST_N),
    .i_load  (tload),
    .i_count (tcount),
    .o_done  (tdone)
  );

  always_comb begin
    is_read = (req_q.cmd == `FBMC_CMD_READ) || (req_q.cmd == `FBMC_CMD_ID_READ) ||
              (req_q.cmd == `FBMC_CMD_PROT_CHK);
    is_hv   = (req_q.cmd == `FBMC_CMD_PROTECT) || (req_q.cmd == `FBMC_CMD_UNPROTECT);
  end

  always_comb begin
    st_d   = st_q;
    req_d  = req_q;
    ctl_d  = ctl_q;
    addr_d = addr_q;
    dout_d = dout_q;
    rdat_d = rdat_q;
    oe_d   = oe_q;
    rvld_d = 1'b0;
    prot_d = prot_q;
    rdy_d  = 1'b0;
    tload  = 1'b0;
    tcount = '0;
    ctl_d.rst_hv = I_TEMP_UNPROT;
    unique case (st_q)
      ST_IDLE: begin
        ctl_d.ce_n        = 1'b1;
        ctl_d.oe_n        = 1'b1;
        ctl_d.we_n        = 1'b1;
        ctl_d.bit_nine_hv = 1'b0;
        ctl_d.oe_hv       = 1'b0;
        oe_d        = 1'b0;
        rdy_d       = 1'b1;
        if (I_REQ_VALID && rdy_q) begin
          req_d = I_REQ;
          rdy_d = 1'b0;
          if (I_REQ.cmd == `FBMC_CMD_RESET) begin
            ctl_d.rst_n = 1'b0;
            tload       = 1'b1;
            tcount      = fbmc_cnt_t'(`FBMC_RST_LOW_CYC);
            st_d        = ST_RST;
          end else begin
            addr_d = I_REQ.addr;
            unique case (I_REQ.cmd)
              `FBMC_CMD_ID_READ: begin
                addr_d[`FBMC_BIT_ONE_POS]  = 1'b0;
                addr_d[`FBMC_BIT_SIX_POS]  = 1'b0;
                ctl_d.bit_nine_hv          = 1'b1;
              end
              `FBMC_CMD_PROTECT, `FBMC_CMD_UNPROTECT: begin
                addr_d[`FBMC_BIT_ZERO_POS] = 1'b0;
                addr_d[`FBMC_BIT_ONE_POS]  = 1'b1;
                addr_d[`FBMC_BIT_SIX_POS]  = (I_REQ.cmd == `FBMC_CMD_UNPROTECT);
                ctl_d.bit_nine_hv          = 1'b1;
                ctl_d.oe_hv          = 1'b1;
              end
              `FBMC_CMD_PROT_CHK: begin
                addr_d = (I_REQ.addr & ~((fbmc_addr_t'(1) << `FBMC_SECT_LSB) - 1'b1)) |
                         `FBMC_PROT_OFS;
              end
              default: begin
                addr_d = I_REQ.addr;
              end
            endcase
            ctl_d.ce_n = 1'b0;
            tload      = 1'b1;
            tcount     = fbmc_cnt_t'(`FBMC_SETUP_CYC);
            st_d       = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (tdone) begin
          tload = 1'b1;
          if (is_read) begin
            ctl_d.oe_n = 1'b0;
            tcount     = fbmc_cnt_t'(`FBMC_ACC_CYC);
            st_d       = ST_WAIT;
          end else begin
            ctl_d.we_n = 1'b0;
            oe_d       = !is_hv;
            dout_d     = req_q.data;
            tcount     = fbmc_cnt_t'(`FBMC_WP_CYC);
            st_d       = ST_PULSE;
          end
        end
      end
      ST_PULSE: begin
        if (tdone) begin
          ctl_d.we_n = 1'b1;
          tload      = 1'b1;
          tcount     = fbmc_cnt_t'(`FBMC_SETUP_CYC);
          st_d       = ST_HOLD;
        end
      end
      ST_WAIT: begin
        if (tdone) begin
          rdat_d = I_DQ_IN;
          rvld_d = 1'b1;
          if (req_q.cmd == `FBMC_CMD_PROT_CHK) begin
            prot_d = I_DQ_IN[0];
          end
          ctl_d.oe_n = 1'b1;
          tload      = 1'b1;
          tcount     = fbmc_cnt_t'(`FBMC_SETUP_CYC);
          st_d       = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tdone) begin
          ctl_d.ce_n        = 1'b1;
          ctl_d.bit_nine_hv = 1'b0;
          ctl_d.oe_hv       = 1'b0;
          oe_d        = 1'b0;
          st_d        = ST_IDLE;
        end
      end
      ST_RST: begin
        if (tdone) begin
          ctl_d.rst_n = 1'b1;
          tload       = 1'b1;
          tcount      = fbmc_cnt_t'(`FBMC_RECOV_CYC);
          st_d        = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (tdone) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // address is held between requests so the device may sleep on stable lines
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q   <= ST_IDLE;
      req_q  <= '0;
      ctl_q  <= `FBMC_CTL_RST;
      addr_q <= '0;
      dout_q <= '0;
      rdat_q <= '0;
      oe_q   <= 1'b0;
      rvld_q <= 1'b0;
      prot_q <= 1'b0;
      rdy_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      req_q  <= req_d;
      ctl_q  <= ctl_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      rdat_q <= rdat_d;
      oe_q   <= oe_d;
      rvld_q <= rvld_d;
      prot_q <= prot_d;
      rdy_q  <= rdy_d;
    end
  end

  assign O_REQ_READY = rdy_q;
  assign O_RD_DATA   = rdat_q;
  assign O_RD_VALID  = rvld_q;
  assign O_PROTECTED = prot_q;
  assign O_CTL       = ctl_q;
  assign O_ADDR      = addr_q;
  assign O_DQ_OUT    = dout_q;
  assign O_DQ_OE     = oe_q;
endmodule

// [testbench/fbmc_host_asserts.sv]
// port checks for the flash host sequencer
`timescale 1ns/100ps
module fbmc_host_asserts
  import fbmc_pkg::*;
(
  input wire logic       I_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_TEMP_UNPROT,
  input wire fbmc_ctl_s  O_CTL,
  input wire fbmc_addr_t O_ADDR,
  input wire fbmc_data_t O_DQ_OUT,
  input wire logic       O_DQ_OE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  a_read_pins: assert property (!O_CTL.oe_n |-> O_CTL.we_n && !O_CTL.ce_n && !O_DQ_OE)
    else $error("read pins bad");
  a_dq_drive: assert property (O_DQ_OE |-> !O_CTL.ce_n && O_CTL.oe_n)
    else $error("data driven outside write");
  a_we_pulse: assert property ($fell(O_CTL.we_n) |=> !O_CTL.we_n [*2])
    else $error("write pulse short");
  a_we_latch: assert property ($rose(O_CTL.we_n) |-> $stable(O_ADDR) && $stable(O_DQ_OUT) && !O_CTL.ce_n)
    else $error("write latch unstable");
  a_prot_pins: assert property (O_CTL.oe_hv |-> O_CTL.bit_nine_hv && O_ADDR[1] && !O_ADDR[0] && !O_DQ_OE)
    else $error("protect pins bad");
  a_id_addr: assert property (!O_CTL.oe_n && O_CTL.bit_nine_hv |-> !O_ADDR[1] && !O_ADDR[6])
    else $error("id read addr bad");
  a_recov_gap: assert property ($rose(O_CTL.rst_n) |-> O_CTL.ce_n [*3])
    else $error("no recovery gap");
  a_temp_hv: assert property ($past(I_RST_N) |-> O_CTL.rst_hv == $past(I_TEMP_UNPROT))
    else $error("temp unprotect lag");
endmodule
bind fbmc_host fbmc_host_asserts fbmc_host_asserts_i (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_TEMP_UNPROT(I_TEMP_UNPROT), .O_CTL(O_CTL), .O_ADDR(O_ADDR), .O_DQ_OUT(O_DQ_OUT), .O_DQ_OE(O_DQ_OE));

// [testbench/fbmc_flash_model.sv]
// behavioural flash answering the host pins
`timescale 1ns/100ps
module fbmc_flash_model
  import fbmc_pkg::*;
#(
  parameter fbmc_data_t MFR_CODE = 16'h0000,
  parameter fbmc_data_t DEV_CODE = 16'h0000
)(
  input  wire logic       i_clk,
  input  wire fbmc_ctl_s  i_ctl,
  input  wire fbmc_addr_t i_addr,
  input  wire fbmc_data_t i_dq,
  output fbmc_data_t      o_dq
);
  fbmc_data_t mem [16] = '{default: 16'h0000};
  logic [3:0] prot = 4'h0;
  fbmc_addr_t waddr = '0;
  fbmc_data_t rd;
  fbmc_data_t last_q = '0;
  logic       drive;
  wire        we_n = i_ctl.we_n;
  wire        ce_n = i_ctl.ce_n;
  always @(negedge we_n or negedge ce_n) begin
    if (!we_n && !ce_n) waddr = i_addr;
  end
  // only the first rising edge sees the other strobe still low
  always @(posedge we_n or posedge ce_n) begin
    if ((!we_n || !ce_n) && i_ctl.rst_n) begin
      if (i_ctl.oe_hv && i_ctl.bit_nine_hv) begin
        if (waddr[6]) prot = 4'h0;
        else prot[waddr[13:12]] = 1'b1;
      end else if (i_ctl.oe_n && (!prot[waddr[13:12]] || i_ctl.rst_hv)) begin
        mem[waddr[3:0]] = i_dq;
      end
    end
  end
  always_comb begin
    drive = !ce_n && !i_ctl.oe_n && we_n && i_ctl.rst_n;
    if (i_ctl.bit_nine_hv && i_addr[1]) rd = {15'h0000, prot[i_addr[13:12]]};
    else if (i_ctl.bit_nine_hv) rd = i_addr[0] ? DEV_CODE : MFR_CODE;
    // id command sequence is taken as already written, so offset 02h reports protection
    else if (i_addr[11:0] == 12'h002) rd = {15'h0000, prot[i_addr[13:12]]};
    else rd = mem[i_addr[3:0]];
  end
  always @(posedge i_clk) begin
    if (drive) last_q <= rd;
  end
  // a floating bus never shows the last word
  assign o_dq = drive ? rd : ~last_q;
endmodule

// [testbench/fbmc_host_test.sv]
// self-checking bench for the flash host sequencer
`timescale 1ns/100ps
module fbmc_host_test;
  import fbmc_pkg::*;
  localparam fbmc_data_t MFR = 16'h00a5; // arbitrary
  localparam fbmc_data_t DEV = 16'h00c3; // arbitrary
  typedef struct packed {logic t; logic [2:0] c; fbmc_addr_t a; fbmc_data_t d; fbmc_data_t e;} fbmc_row_s;
  localparam fbmc_row_s ROWS [17] = '{
    '{0, 1, 20'h00003, 16'h1234, 0}, '{0, 0, 20'h00003, 0, 16'h1234},
    '{0, 2, 20'h00000, 0, MFR}, '{0, 2, 20'h00001, 0, DEV},
    '{0, 3, 20'h01000, 0, 0}, '{0, 6, 20'h01000, 0, 1},
    '{0, 1, 20'h01004, 16'h5555, 0}, '{0, 0, 20'h01004, 0, 0},
    '{0, 4, 20'h01000, 0, 0}, '{0, 6, 20'h01000, 0, 0},
    '{1, 3, 20'h01000, 0, 0}, '{1, 1, 20'h01004, 16'h5555, 0},
    '{1, 0, 20'h01004, 0, 16'h5555}, '{0, 1, 20'h01004, 16'haaaa, 0},
    '{0, 0, 20'h01004, 0, 16'h5555}, '{0, 5, 0, 0, 0}, '{0, 0, 20'h00003, 0, 16'h1234}};
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       vld = 1'b0;
  logic       tu = 1'b0;
  fbmc_req_s  req = '0;
  fbmc_data_t dq_in, rd_data, dq_out, r;
  fbmc_addr_t addr;
  fbmc_ctl_s  ctl;
  logic       rdy, rd_vld, prot, dq_oe;
  int         mismatches = 0;
  int         n_tests = 0;
  int         cyc = 0;
  always #20 clk = ~clk;
  fbmc_host fbmc_host_i (.I_CLK(clk), .I_RST_N(rst_n), .I_REQ(req), .I_REQ_VALID(vld), .I_TEMP_UNPROT(tu),
    .I_DQ_IN(dq_in), .O_REQ_READY(rdy), .O_RD_DATA(rd_data), .O_RD_VALID(rd_vld), .O_PROTECTED(prot),
    .O_CTL(ctl), .O_ADDR(addr), .O_DQ_OUT(dq_out), .O_DQ_OE(dq_oe));
  fbmc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fbmc_flash_model_i (.i_clk(clk), .i_ctl(ctl),
    .i_addr(addr), .i_dq(dq_out), .o_dq(dq_in));
  task automatic chk(input fbmc_data_t seen, input fbmc_data_t exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ready is sampled before the edge lands, so a take happens one edge after raising valid
  task automatic do_req(input logic [2:0] c, input fbmc_addr_t a, input fbmc_data_t d, output fbmc_data_t q);
    int n;
    n = 0;
    q = '0;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    req <= '{c, a, d};
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    if (c inside {3'h0, 3'h2, 3'h6}) begin
      while (rd_vld !== 1'b1 && n < 80) begin
        @(posedge clk);
        n++;
      end
      q = (c == 3'h6) ? {15'h0000, prot} : rd_data;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[k]) begin
      tu <= ROWS[k].t;
      do_req(ROWS[k].c, ROWS[k].a, ROWS[k].d, r);
      if (ROWS[k].c inside {3'h0, 3'h2, 3'h6}) chk(r, ROWS[k].e);
    end
    while (rdy !== 1'b1) @(posedge clk);
    req <= '{3'h0, 20'h00003, 16'h0000};
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({11'h000, ctl.ce_n, ctl.oe_n, ctl.rst_n, dq_oe, rdy}, 16'h001c);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({14'h0000, ctl.ce_n, rdy}, 16'h0003);
    do_req(3'h0, 20'h00003, 16'h0000, r);
    chk(r, 16'h1234);
    print_verdict();
  end
endmodule
